// file: core/frp_ctrl.sv
// Flash rewrite and protect controller: APB registers, program/erase sequencer, suspend.
// Assumes an array macro that follows the level enables, and straps and identity given.
//
// Notes on behaviour
// R1 - Blocks 0/1 need master enable 1 and own lock 0.
// R2 - Boot area shares user addresses; mode selects it.
// R3 - Serial mode, non-blank: identity mismatch ignores later commands.
// R4 - Identity is seven bytes at fixed locations, first to last.
// R5 - Protect 0 with confirm 1 bars parallel read and write.
// R6 - Only CPU or serial erase of option block lifts protection; the code starts no erase in serial mode.
// R7 - Option byte reads all ones after its block is erased.
// R8 - Software programs and erases user-area blocks only.
// R9 - Interrupt during erase pauses it; user area readable.
// R10 - Interrupt during program pauses it; user area readable.
// R11 - First mode runs from RAM; second may run from flash.
// R12 - Second mode: no rewrite of running block, no status read.
// R13 - After operation: first mode status read, second array read.
// R14 - Second mode holds CPU and ports during operation.
// R15 - Ready and error flags in control reg; status copy first mode.
// R16 - Erase suspend: software request first mode, interrupt second.
// R17 - Program suspend: software request first mode, interrupt second.
// R18 - Option byte programmed once only.
// R19 - Mode bit selects second mode after rewrite enable.
// R20 - Ready 0 during program, erase and suspend; else 1.
// R21 - Read-enable 0 while executing, 1 in suspend.
// R22 - Software clears suspend request to resume.
// R23 - Command to locked block changes nothing; stays idle.
// R24 - Blank when all identity bytes read all ones.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module frp_ctrl #(
   parameter logic [23:0] ERASE_CYCLES = frp_pkg::ERASE_CYC  // Erase duration in cycles
) (
   input  wire logic        core_clk, // Clock, 40 MHz
   input  wire logic        rst, // Sync reset
   input  wire logic        psel, // APB select
   input  wire logic        penable, // APB access
   input  wire logic        pwrite, // APB write
   input  wire logic [7:0]  paddr, // APB address
   input  wire logic [31:0] pwdata, // APB write data
   output logic      [31:0] prdata, // APB read data
   output logic             pready, // APB ready
   output logic             pslverr, // Unmapped address
   input  wire logic        irq_req, // Enabled interrupt
   input  wire logic [19:0] cpu_fetch_addr, // CPU fetch address
   input  wire logic        boot_mode, // Serial mode strap
   input  wire logic        parallel_mode, // Parallel strap
   input  wire logic [7:0]  option_byte, // Option byte
   input  wire logic [55:0] stored_id, // Identity, first low
   input  wire logic        id_rx_valid, // Identity byte in
   input  wire logic [7:0]  id_rx_byte, // Its value
   input  wire logic        arr_fail, // Verify failure
   output logic             arr_prog_en, // Program enable
   output logic             arr_erase_en, // Erase enable
   output logic             arr_suspend, // Paused
   output logic      [19:0] arr_addr, // Target address
   output logic      [7:0]  arr_wdata, // Program data
   output logic             read_status_mode, // Status reads
   output logic             boot_area_sel, // Boot area mapped
   output logic             cpu_hold, // CPU and ports held
   output logic             serial_cmd_enable, // Serial commands open
   output logic             parallel_protect // Parallel barred
);

   ////////////////////////////////////////
   // Functions

   function automatic logic [1:0] block_of(input logic [19:0] a);
      if (a >= frp_pkg::BLK0_LO && a <= frp_pkg::BLK0_HI) begin
         return frp_pkg::BLK_0;
      end else if (a >= frp_pkg::BLK1_LO && a <= frp_pkg::BLK1_HI) begin
         return frp_pkg::BLK_1;
      end else if (a >= frp_pkg::USER_LO && a <= frp_pkg::USER_HI) begin
         return frp_pkg::BLK_OTHER;
      end else begin
         return frp_pkg::BLK_OUTSIDE;
      end
   endfunction

   function automatic logic [7:0] id_byte(input logic [55:0] ids, input logic [2:0] idx);
      return ids[8*idx +: 8];
   endfunction

   ////////////////////////////////////////
   // State

   frp_pkg::frp_state_type state_ff, nxt_state;
   logic [23:0] cnt_ff, nxt_cnt;
   logic        cpu_en_ff, low_en_ff, mode_ff, lock0_ff, lock1_ff;
   logic        susp_en_ff, esreq_ff, psreq_ff, nxt_esreq, nxt_psreq;
   logic        perr_ff, eerr_ff, nxt_perr, nxt_eerr;
   logic [19:0] addr_ff;
   logic [7:0]  wdata_ff;
   logic        rsm_ff, nxt_rsm;
   logic        opt_erased_ff;
   logic [2:0]  id_idx_ff;
   logic        id_bad_ff;
   logic        boot_ff;
   logic [31:0] prdata_ff;

   ////////////////////////////////////////
   // APB decode

   wire wr_strobe = psel & penable & pwrite;
   wire setup     = psel & ~penable;
   wire hit_c0    = (paddr == frp_pkg::CTRL0_OFS);
   wire hit_c1    = (paddr == frp_pkg::CTRL1_OFS);
   wire hit_c4    = (paddr == frp_pkg::CTRL4_OFS);
   wire hit_cmd   = (paddr == frp_pkg::CMD_OFS);
   wire hit_addr  = (paddr == frp_pkg::ADDR_OFS);
   wire hit_wdat  = (paddr == frp_pkg::WDATA_OFS);
   wire hit_stat  = (paddr == frp_pkg::STATUS_OFS);
   wire mapped    = hit_c0 | hit_c1 | hit_c4 | hit_cmd | hit_addr | hit_wdat | hit_stat;
   wire wr_c0     = wr_strobe & hit_c0;
   wire wr_c1     = wr_strobe & hit_c1;
   wire wr_c4     = wr_strobe & hit_c4;
   wire wr_cmd    = wr_strobe & hit_cmd;

   ////////////////////////////////////////
   // Status views

   wire ew1       = cpu_en_ff & mode_ff;
   wire idle      = (state_ff == frp_pkg::ST_IDLE);
   wire prog_run  = (state_ff == frp_pkg::ST_PROG);
   wire erase_run = (state_ff == frp_pkg::ST_ERASE);
   wire prog_busy = prog_run | (state_ff == frp_pkg::ST_PROG_SUSP);
   wire erase_busy = erase_run | (state_ff == frp_pkg::ST_ERASE_SUSP);
   // R20 ready flag
   wire ready_flag = idle;
   // R21 read-enable flag
   wire rd_en_flag = ~(prog_run | erase_run);

   wire [31:0] c0_view = {24'h00_0000, eerr_ff, perr_ff, 3'b000, low_en_ff, cpu_en_ff, ready_flag};
   wire [31:0] c1_view = {25'h000_0000, lock1_ff, lock0_ff, 3'b000, mode_ff, 1'b0};
   wire [31:0] c4_view = {25'h000_0000, rd_en_flag, 1'b0, prog_busy, erase_busy,
                          psreq_ff, esreq_ff, susp_en_ff};
   // R15 status register copy only in first mode
   wire [31:0] st_view = ew1 ? 32'h0000_0000 :
                         {24'h00_0000, ready_flag, 1'b0, eerr_ff, perr_ff, 4'h0};
   wire [31:0] rd_mux  = hit_c0   ? c0_view :
                         hit_c1   ? c1_view :
                         hit_c4   ? c4_view :
                         hit_addr ? {12'h000, addr_ff} :
                         hit_wdat ? {24'h00_0000, wdata_ff} :
                         hit_stat ? st_view : 32'h0000_0000;

   ////////////////////////////////////////
   // Command acceptance

   wire [2:0] cmd_code  = pwdata[2:0];
   wire [1:0] tgt_blk   = block_of(addr_ff);
   // R1 low block gating
   wire blk_open = (tgt_blk == frp_pkg::BLK_OTHER) |
                   ((tgt_blk == frp_pkg::BLK_0) & low_en_ff & ~lock0_ff) |
                   ((tgt_blk == frp_pkg::BLK_1) & low_en_ff & ~lock1_ff);
   // R12 running block excluded in second mode
   wire own_blk  = ew1 & (block_of(cpu_fetch_addr) == tgt_blk);
   // R23 locked or illegal target is dropped
   wire target_ok = blk_open & ~own_blk & ~boot_ff;
   wire cmd_ok    = wr_cmd & cpu_en_ff & idle;
   wire start_prog  = cmd_ok & (cmd_code == frp_pkg::CMD_PROGRAM) & target_ok;
   wire start_erase = cmd_ok & (cmd_code == frp_pkg::CMD_ERASE) & target_ok;
   wire done        = (prog_run | erase_run) & (cnt_ff == 24'h00_0000);
   // R7 erase of the option byte block
   wire opt_erase_done = erase_run & done & ~arr_fail &
                         (block_of(addr_ff) == block_of(frp_pkg::OPT_ADDR));

   ////////////////////////////////////////
   // Suspend requests

   // R16 erase suspend request, interrupt sets it in second mode
   wire hw_esreq = ew1 & susp_en_ff & irq_req & erase_run;
   // R17 program suspend request, interrupt sets it in second mode
   wire hw_psreq = ew1 & susp_en_ff & irq_req & prog_run;

   always_comb begin
      nxt_esreq = esreq_ff;
      nxt_psreq = psreq_ff;
      if (wr_c4) begin
         nxt_esreq = pwdata[frp_pkg::C4_ESREQ];
         nxt_psreq = pwdata[frp_pkg::C4_PSREQ];
      end
      if (done) begin
         nxt_esreq = 1'b0;
         nxt_psreq = 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle
      if (hw_esreq) begin
         nxt_esreq = 1'b1;
      end
      if (hw_psreq) begin
         nxt_psreq = 1'b1;
      end
   end

   ////////////////////////////////////////
   // Sequencer

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         frp_pkg::ST_IDLE: begin
            if (start_prog) begin
               nxt_state = frp_pkg::ST_PROG;
               nxt_cnt   = frp_pkg::PROG_CYC;
            end else if (start_erase) begin
               nxt_state = frp_pkg::ST_ERASE;
               nxt_cnt   = ERASE_CYCLES;
            end
         end
         frp_pkg::ST_PROG: begin
            if (done) begin
               nxt_state = frp_pkg::ST_IDLE;
            end else begin
               // The pausing cycle counts, so a suspend never stretches the run
               nxt_cnt = cnt_ff - 24'h00_0001;
               // R10 pause program on request
               if (susp_en_ff & psreq_ff) begin
                  nxt_state = frp_pkg::ST_PROG_SUSP;
               end
            end
         end
         frp_pkg::ST_PROG_SUSP: begin
            // R22 resume on cleared request
            if (~psreq_ff) begin
               nxt_state = frp_pkg::ST_PROG;
            end
         end
         frp_pkg::ST_ERASE: begin
            if (done) begin
               nxt_state = frp_pkg::ST_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 24'h00_0001;
               // R9 pause erase on request
               if (susp_en_ff & esreq_ff) begin
                  nxt_state = frp_pkg::ST_ERASE_SUSP;
               end
            end
         end
         frp_pkg::ST_ERASE_SUSP: begin
            if (~esreq_ff) begin
               nxt_state = frp_pkg::ST_ERASE;
            end
         end
         default: begin
            nxt_state = frp_pkg::ST_IDLE;
         end
      endcase
   end

   always_comb begin
      nxt_perr = perr_ff;
      nxt_eerr = eerr_ff;
      nxt_rsm  = rsm_ff;
      if (cmd_ok & (cmd_code == frp_pkg::CMD_CLR_STAT)) begin
         nxt_perr = 1'b0;
         nxt_eerr = 1'b0;
      end
      // R12 status read command ignored in second mode
      if (cmd_ok & (cmd_code == frp_pkg::CMD_RD_STAT) & ~ew1) begin
         nxt_rsm = 1'b1;
      end
      if (cmd_ok & (cmd_code == frp_pkg::CMD_RD_ARRAY)) begin
         nxt_rsm = 1'b0;
      end
      // R15 error flags from the array result
      if (done & prog_run & arr_fail) begin
         nxt_perr = 1'b1;
      end
      if (done & erase_run & arr_fail) begin
         nxt_eerr = 1'b1;
      end
      // R13 state after the operation depends on mode
      if (done) begin
         nxt_rsm = ~ew1;
      end
      if (~cpu_en_ff) begin
         nxt_rsm = 1'b0;
      end
   end

   ////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= frp_pkg::ST_IDLE;
         cnt_ff   <= 24'h00_0000;
         esreq_ff <= 1'b0;
         psreq_ff <= 1'b0;
         perr_ff  <= 1'b0;
         eerr_ff  <= 1'b0;
         rsm_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         esreq_ff <= nxt_esreq;
         psreq_ff <= nxt_psreq;
         perr_ff  <= nxt_perr;
         eerr_ff  <= nxt_eerr;
         rsm_ff   <= nxt_rsm;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_en_ff  <= 1'b0;
         low_en_ff  <= 1'b0;
         mode_ff    <= 1'b0;
         lock0_ff   <= frp_pkg::RST_LOCK;
         lock1_ff   <= frp_pkg::RST_LOCK;
         susp_en_ff <= 1'b0;
      end else begin
         if (wr_c0) begin
            cpu_en_ff <= pwdata[frp_pkg::C0_CPU_EN];
            low_en_ff <= pwdata[frp_pkg::C0_LOW_EN];
         end
         // R19 mode bit takes 1 only once rewrite is enabled
         if (wr_c0 & ~pwdata[frp_pkg::C0_CPU_EN]) begin
            mode_ff <= 1'b0;
         end else if (wr_c1) begin
            mode_ff <= pwdata[frp_pkg::C1_MODE] & cpu_en_ff;
         end
         if (wr_c1) begin
            lock0_ff <= pwdata[frp_pkg::C1_LOCK0];
            lock1_ff <= pwdata[frp_pkg::C1_LOCK1];
         end
         if (wr_c4) begin
            susp_en_ff <= pwdata[frp_pkg::C4_SUSP_EN];
         end
      end
   end

   // Target latches are frozen while an operation is in flight
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_ff  <= 20'h0_0000;
         wdata_ff <= 8'h00;
      end else if (idle) begin
         if (wr_strobe & hit_addr) begin
            addr_ff <= pwdata[19:0];
         end
         if (wr_strobe & hit_wdat) begin
            wdata_ff <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   ////////////////////////////////////////
   // Protection

   // R6 cleared only by a completed CPU erase; no erase starts in serial mode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         opt_erased_ff <= 1'b0;
      end else if (opt_erase_done) begin
         opt_erased_ff <= 1'b1;
      end
   end

   // R7 erased option byte reads all ones
   wire [7:0] opt_eff = opt_erased_ff ? frp_pkg::ERASED_BYTE : option_byte;
   // R5 protect active on bit 0 and confirm 1
   wire protect_on = ~opt_eff[frp_pkg::OPT_PROTECT] & opt_eff[frp_pkg::OPT_CONFIRM];

   // R24 blank when every identity byte is erased
   wire id_blank = (stored_id == {frp_pkg::ID_COUNT{frp_pkg::ERASED_BYTE}});
   wire id_full  = (id_idx_ff == 3'(frp_pkg::ID_COUNT));

   // R4 received bytes compared in location order
   always_ff @(posedge core_clk) begin
      if (rst) begin
         id_idx_ff <= 3'h0;
         id_bad_ff <= 1'b0;
         boot_ff   <= 1'b0;
      end else begin
         boot_ff <= boot_mode;
         if (boot_mode & id_rx_valid & ~id_full) begin
            id_idx_ff <= id_idx_ff + 3'h1;
            // R3 any mismatch is sticky
            if (id_rx_byte != id_byte(stored_id, id_idx_ff)) begin
               id_bad_ff <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////
   // Outputs

   assign prdata       = prdata_ff;
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped;
   assign arr_prog_en  = prog_busy;
   assign arr_erase_en = erase_busy;
   assign arr_suspend  = (state_ff == frp_pkg::ST_PROG_SUSP) | (state_ff == frp_pkg::ST_ERASE_SUSP);
   assign arr_addr     = addr_ff;
   assign arr_wdata    = wdata_ff;
   assign read_status_mode = rsm_ff;
   // R2 boot area selected by operating mode
   assign boot_area_sel = boot_ff;
   // R14 second mode holds CPU while running
   assign cpu_hold     = ew1 & (prog_run | erase_run);
   // R3 commands gated by identity result
   assign serial_cmd_enable = boot_ff & (id_blank | (id_full & ~id_bad_ff));
   assign parallel_protect  = parallel_mode & protect_on;

endmodule // frp_ctrl

`default_nettype wire

// file: core/frp_pkg.sv
// Flash rewrite-protect constants: register map, fields, blocks, identity, timing.
// Assumes a 40 MHz core clock and 20-bit byte addresses.
package frp_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] CTRL0_OFS  = 8'h00;
   localparam logic [7:0] CTRL1_OFS  = 8'h04;
   localparam logic [7:0] CTRL4_OFS  = 8'h08;
   localparam logic [7:0] CMD_OFS    = 8'h0C;
   localparam logic [7:0] ADDR_OFS   = 8'h10;
   localparam logic [7:0] WDATA_OFS  = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;

   // flash_control_reg0 fields
   localparam int C0_READY   = 0;
   localparam int C0_CPU_EN  = 1;
   localparam int C0_LOW_EN  = 2;
   localparam int C0_PERR    = 6;
   localparam int C0_EERR    = 7;
   // flash_control_reg1 fields
   localparam int C1_MODE    = 1;
   localparam int C1_LOCK0   = 5;
   localparam int C1_LOCK1   = 6;
   // flash_control_reg4 fields
   localparam int C4_SUSP_EN = 0;
   localparam int C4_ESREQ   = 1;
   localparam int C4_PSREQ   = 2;
   localparam int C4_EBUSY   = 3;
   localparam int C4_PBUSY   = 4;
   localparam int C4_RD_EN   = 6;
   // Status register fields
   localparam int ST_PERR    = 4;
   localparam int ST_EERR    = 5;
   localparam int ST_READY   = 7;

   // Reset value of the lock bits: both blocks locked
   localparam logic RST_LOCK = 1'b1;

   // Command codes written to the command register
   localparam logic [2:0] CMD_PROGRAM  = 3'h1;
   localparam logic [2:0] CMD_ERASE    = 3'h2;
   localparam logic [2:0] CMD_RD_STAT  = 3'h3;
   localparam logic [2:0] CMD_CLR_STAT = 3'h4;
   localparam logic [2:0] CMD_RD_ARRAY = 3'h5;

   // Block map (byte addresses)
   localparam logic [19:0] USER_LO     = 20'h0_C000;
   localparam logic [19:0] USER_HI     = 20'h0_FFFF;
   localparam logic [19:0] BLK1_LO     = 20'h0_C000;
   localparam logic [19:0] BLK1_HI     = 20'h0_DFFF;
   localparam logic [19:0] BLK0_LO     = 20'h0_E000;
   localparam logic [19:0] BLK0_HI     = 20'h0_FFFF;
   localparam logic [19:0] OPT_ADDR    = 20'h0_FFFF;
   localparam logic [1:0]  BLK_0       = 2'h0;
   localparam logic [1:0]  BLK_1       = 2'h1;
   localparam logic [1:0]  BLK_OTHER   = 2'h2;
   localparam logic [1:0]  BLK_OUTSIDE = 2'h3;

   // Identity byte locations, first to last
   localparam int ID_COUNT = 7;
   localparam logic [19:0] ID_ADDR [ID_COUNT] = '{20'h0_FFDF, 20'h0_FFE3, 20'h0_FFEB, 20'h0_FFEB,
                                                  20'h0_FFEF, 20'h0_FFF7, 20'h0_FFFB};
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;

   // Option byte fields
   localparam int OPT_PROTECT = 0;
   localparam int OPT_CONFIRM = 1;

   // Timing
   localparam int CLK_MHZ       = 40;
   localparam int PROG_TIME_US  = 50;
   localparam int ERASE_TIME_MS = 300;
   localparam logic [23:0] PROG_CYC  = 24'(PROG_TIME_US * CLK_MHZ);
   localparam logic [23:0] ERASE_CYC = 24'(ERASE_TIME_MS * 1000 * CLK_MHZ);

   typedef enum logic [2:0] {
      ST_IDLE       = 3'b000,
      ST_PROG       = 3'b001,
      ST_PROG_SUSP  = 3'b011,
      ST_ERASE      = 3'b100,
      ST_ERASE_SUSP = 3'b101
   } frp_state_type;

endpackage

// file: tb/frp_ctrl_chk.sv
// Port checker for frp_ctrl.
// Bound to every frp_ctrl instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module frp_ctrl_chk #(
   parameter logic [23:0] ERASE_CYCLES = frp_pkg::ERASE_CYC  // Erase length
) (
   input wire logic       core_clk,          // Clock
   input wire logic       rst,               // Reset
   input wire logic       boot_mode,         // Boot strap
   input wire logic       parallel_mode,     // Parallel strap
   input wire logic [7:0] option_byte,       // Option byte
   input wire logic       arr_prog_en,       // Program
   input wire logic       arr_erase_en,      // Erase
   input wire logic       arr_suspend,       // Paused
   input wire logic       cpu_hold,          // CPU held
   input wire logic       boot_area_sel,     // Boot area
   input wire logic       serial_cmd_enable, // Serial open
   input wire logic       parallel_protect   // Parallel barred
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [11:0] run_ff;
   // Paused cycles do not count, so a suspended program still owes its full time
   always_ff @(posedge core_clk) begin
      if (rst || !arr_prog_en) run_ff <= 12'h000;
      else if (!arr_suspend) run_ff <= run_ff + 12'h001;
   end
   ////////////////////////////////////////
   a_prog_len: assert property ($fell(arr_prog_en) |-> run_ff == 12'h7D1)
      else $error("program length wrong");
   a_prot_cause: assert property (parallel_protect |-> parallel_mode && !option_byte[0] && option_byte[1])
      else $error("protect without cause");
   a_prot_mode: assert property (!parallel_mode |-> !parallel_protect)
      else $error("protect outside parallel mode");
   a_hold_run: assert property (cpu_hold |-> (arr_prog_en || arr_erase_en) && !arr_suspend)
      else $error("hold outside running operation");
   a_susp_busy: assert property (arr_suspend |-> arr_prog_en ^ arr_erase_en)
      else $error("suspend without one operation");
   a_boot_sel: assert property (boot_mode |=> boot_area_sel)
      else $error("boot area not selected");
   a_boot_off: assert property (!boot_mode |=> !boot_area_sel)
      else $error("boot area selected");
   a_serial_boot: assert property (serial_cmd_enable |-> boot_mode)
      else $error("serial open outside boot");
   c_prog: cover property ($fell(arr_prog_en));
   c_susp: cover property (cpu_hold ##[1:4] arr_suspend);
   c_id: cover property ($rose(serial_cmd_enable));
endmodule // frp_ctrl_chk
bind frp_ctrl frp_ctrl_chk #(.ERASE_CYCLES(ERASE_CYCLES)) i_frp_ctrl_chk (.core_clk, .rst, .boot_mode,
   .parallel_mode, .option_byte, .arr_prog_en, .arr_erase_en, .arr_suspend, .cpu_hold, .boot_area_sel,
   .serial_cmd_enable, .parallel_protect);
`default_nettype wire

// file: tb/frp_arr_model.sv
// Flash array model: identity bytes, armed option byte, verify failure on demand.
// Assumes the controller holds its enables for the whole operation.
`timescale 1ns/1ps
`default_nettype none
module frp_arr_model #(
   parameter logic [55:0] ID_VAL = 56'h1234_5678_9ABC_DE  // Arbitrary identity
) (
   input  wire logic        arr_prog_en,  // Program
   input  wire logic        arr_erase_en, // Erase
   input  wire logic        fail_next,    // Bench asks for a failure
   output logic             arr_fail,     // Verify failure
   output logic      [7:0]  option_byte,  // Option byte
   output logic      [55:0] stored_id     // Identity
);
   assign stored_id = ID_VAL;
   assign option_byte = 8'h02;
   assign arr_fail = fail_next & (arr_prog_en | arr_erase_en);
endmodule // frp_arr_model
`default_nettype wire

// file: tb/frp_ctrl_tb_top.sv
// Self-checking bench for frp_ctrl: APB master, array model, straps.
// Assumes frp_pkg, frp_ctrl and the tb files compiled first.
`timescale 1ns/1ps
`default_nettype none
module frp_ctrl_tb_top;
   localparam logic [55:0] ID_VAL = 56'h1234_5678_9ABC_DE;  // Arbitrary identity
   logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_req = 1'b0;
   logic boot_mode = 1'b0, parallel_mode = 1'b1, id_rx_valid = 1'b0, fail_next = 1'b0, serr;
   logic [7:0]  paddr = 8'h00, id_rx_byte = 8'h00;
   logic [19:0] cpu_fetch_addr = 20'h0_8000;
   logic [31:0] pwdata = 32'h0, rdat;
   wire logic [31:0] prdata;
   wire logic [19:0] arr_addr;
   wire logic [7:0]  arr_wdata, option_byte;
   wire logic [55:0] stored_id;
   wire logic pready, pslverr, arr_fail, arr_prog_en, arr_erase_en, arr_suspend, read_status_mode;
   wire logic boot_area_sel, cpu_hold, serial_cmd_enable, parallel_protect;
   int err_total = 0, tests_run = 0;
   // Rows: write flag, address, write data, read-back
   logic [72:0] rows [10] = '{{1'b0, 8'h00, 32'h0, 32'h1}, {1'b0, 8'h04, 32'h0, 32'h60},
      {1'b0, 8'h08, 32'h0, 32'h40}, {1'b0, 8'h18, 32'h0, 32'h80}, {1'b1, 8'h00, 32'h6, 32'h7},
      {1'b1, 8'h04, 32'h2, 32'h2}, {1'b0, 8'h18, 32'h0, 32'h0}, {1'b1, 8'h04, 32'h60, 32'h60},
      {1'b1, 8'h08, 32'h1, 32'h41}, {1'b1, 8'h0C, 32'h5, 32'h0}};
   always #12.5 core_clk = ~core_clk;
   frp_ctrl #(.ERASE_CYCLES(24'h32)) i_frp_ctrl (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq_req, .cpu_fetch_addr, .boot_mode, .parallel_mode, .option_byte,
      .stored_id, .id_rx_valid, .id_rx_byte, .arr_fail, .arr_prog_en, .arr_erase_en, .arr_suspend, .arr_addr,
      .arr_wdata, .read_status_mode, .boot_area_sel, .cpu_hold, .serial_cmd_enable, .parallel_protect);
   frp_arr_model #(.ID_VAL(ID_VAL)) i_frp_arr_model (.arr_prog_en, .arr_erase_en, .fail_next, .arr_fail,
      .option_byte, .stored_id);
   ////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic s);
      chk(nm, {31'h0, e}, {31'h0, s});
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 3000 && (arr_prog_en | arr_erase_en) !== 1'b0; n++) @(posedge core_clk);
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chkb("protect", 1'b1, parallel_protect);
      foreach (rows[i]) begin
         if (rows[i][72]) apb(1'b1, rows[i][71:64], rows[i][63:32]);
         apb(1'b0, rows[i][71:64], 32'h0);
         chk("register", rows[i][31:0], rdat);
      end
      apb(1'b0, 8'h1C, 32'h0);
      chkb("slverr", 1'b1, serr);
      apb(1'b1, 8'h10, 32'hE000);
      apb(1'b1, 8'h0C, 32'h1);
      chkb("locked", 1'b0, arr_prog_en);
      apb(1'b1, 8'h00, 32'h2);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h0C, 32'h1);
      chkb("master", 1'b0, arr_prog_en);
      apb(1'b1, 8'h00, 32'h6);
      apb(1'b1, 8'h10, 32'hC000);
      apb(1'b1, 8'h14, 32'h5A);
      fail_next <= 1'b1;
      apb(1'b1, 8'h0C, 32'h1);
      chk("arr_addr", 32'hC000, {12'h000, arr_addr});
      chk("arr_wdata", 32'h5A, {24'h00_0000, arr_wdata});
      wait_idle();
      fail_next <= 1'b0;
      chkb("status_mode", 1'b1, read_status_mode);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl0", 32'h47, rdat);
      apb(1'b0, 8'h18, 32'h0);
      chk("status", 32'h90, rdat);
      apb(1'b1, 8'h10, 32'hE000);
      apb(1'b1, 8'h0C, 32'h2);
      apb(1'b1, 8'h08, 32'h3);
      @(posedge core_clk);
      chkb("erase_susp", 1'b1, arr_suspend);
      apb(1'b0, 8'h00, 32'h0);
      chk("ready", 32'h46, rdat);
      apb(1'b0, 8'h08, 32'h0);
      chk("ctrl4", 32'h4B, rdat);
      apb(1'b1, 8'h08, 32'h1);
      wait_idle();
      chkb("unprotect", 1'b0, parallel_protect);
      apb(1'b1, 8'h04, 32'h2);
      cpu_fetch_addr <= 20'h0_E100;
      apb(1'b1, 8'h10, 32'hE000);
      apb(1'b1, 8'h0C, 32'h1);
      chkb("own_block", 1'b0, arr_prog_en);
      apb(1'b1, 8'h10, 32'hC000);
      apb(1'b1, 8'h0C, 32'h1);
      chkb("hold", 1'b1, cpu_hold);
      irq_req <= 1'b1;
      @(posedge core_clk);
      irq_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      chkb("prog_susp", 1'b1, arr_suspend);
      apb(1'b0, 8'h08, 32'h0);
      chk("ctrl4_irq", 32'h55, rdat);
      apb(1'b1, 8'h08, 32'h1);
      wait_idle();
      chkb("array_mode", 1'b0, read_status_mode);
      for (int r = 0; r < 2; r++) begin
         rst <= 1'b1;
         boot_mode <= 1'b1;
         @(posedge core_clk);
         rst <= 1'b0;
         for (int k = 0; k < 7; k++) begin
            @(posedge core_clk);
            id_rx_valid <= 1'b1;
            id_rx_byte <= ID_VAL[8*k+:8] ^ {7'h00, r == 1 && k == 0};
         end
         @(posedge core_clk);
         id_rx_valid <= 1'b0;
         repeat (2) @(posedge core_clk);
         chkb("identity", r == 0, serial_cmd_enable);
      end
      chkb("boot_area", 1'b1, boot_area_sel);
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      give_verdict();
   end
endmodule // frp_ctrl_tb_top
`default_nettype wire
